// ### clock_mode_pkg.sv
/*
  constants for the clock-source mode and selection block.
  assumes an 8-bit internal register port with byte and bit writes.
*/
// What this block and its software must do
// R1 - pin mode register writable once per reset
// R2 - pin mode register always readable whole
// R3 - pin mode register resets to zero
// R4 - bits 7:6 decode main pin mode
// R5 - bits 5:4 decode subsystem pin mode
// R6 - bits 2:1 set subsystem drive; 11 forbidden
// R7 - bit 0 selects main frequency range
// R8 - software writes pin mode before oscillators
// R9 - software sets drive bits on onchip clock
// R10 - select register resets zero, bit/byte writable
// R11 - bit 7 reports cpu clock in use
// R12 - bit 6 requests cpu clock source
// R13 - bit 5 reports main source in use
// R14 - bit 4 requests main clock source
// R15 - software keeps bit 4 while subsystem requested
// R16 - software writes zero to low nibble
// R17 - peripherals follow cpu clock, some excepted
// R18 - halt bit stops main oscillator
// R19 - glitch-free switch, status after actual change
package clock_mode_pkg;
  localparam logic [19:0] pin_osc_mode_addr  = 20'hfffa0;
  localparam logic [19:0] sys_clock_sel_addr = 20'hfffa4;
  localparam logic [7:0]  pin_osc_mode_rst   = 8'h00;
  localparam logic [7:0]  sys_clock_sel_rst  = 8'h00;
  localparam int main_ext_bit    = 7;
  localparam int main_osc_bit    = 6;
  localparam int sub_ext_bit     = 5;
  localparam int sub_osc_bit     = 4;
  localparam int sub_drive_hi_bit = 2;
  localparam int sub_drive_lo_bit = 1;
  localparam int main_freq_bit   = 0;
  localparam int cpu_status_bit  = 7;
  localparam int cpu_choice_bit  = 6;
  localparam int main_status_bit = 5;
  localparam int main_choice_bit = 4;
  localparam logic [7:0] sys_clock_wr_mask = 8'h50;
  localparam logic [1:0] pin_input_port = 2'h0;
  localparam logic [1:0] pin_crystal    = 2'h1;
  localparam logic [1:0] pin_ext_clock  = 2'h2;
  // synchroniser depth used by the glitch-free switch
  localparam int sync_stages = 2;
  typedef enum logic [3:0] {
    sw_idle   = 4'b0001,
    sw_off    = 4'b0010,
    sw_wait   = 4'b0100,
    sw_on     = 4'b1000
  } switch_state_type;
endpackage

// ### clock_source_mode_select.sv
/*
  clock-source mode register and system clock select register.
  assumes one byte-wide register port with a per-bit write mask;
  oscillator ready levels come from the analog macros, synchronous.
*/
`timescale 1ns/1ps
module clock_source_mode_select
  import clock_mode_pkg::*;
(
  input  wire logic        ref_clk_i,
  input  wire logic        rstn_i,
  input  wire logic [19:0] addr_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  bit_mask_i,
  input  wire logic [7:0]  wdata_i,
  input  wire logic        main_osc_halt_i,
  input  wire logic        main_ready_i,
  input  wire logic        sub_ready_i,
  output logic [7:0]       rdata_o,
  output logic [1:0]       main_pin_mode_o,
  output logic [1:0]       sub_pin_mode_o,
  output logic [1:0]       sub_drive_o,
  output logic             main_freq_range_o,
  output logic             main_osc_enable_o,
  output logic             onchip_gate_o,
  output logic             main_ext_gate_o,
  output logic             main_clk_gate_o,
  output logic             sub_clk_gate_o
);
  logic [7:0] pin_osc_mode_reg;
  logic       mode_written;
  logic       main_source_choice;
  logic       cpu_clock_choice;
  logic       main_source_status;
  logic       cpu_clock_status;
  logic       onchip_gate;
  logic       main_ext_gate;
  logic       main_gate;
  logic       sub_gate;

  wire sel_mode = addr_i == pin_osc_mode_addr;
  wire sel_sys  = addr_i == sys_clock_sel_addr;
  // only a full byte write counts as the single allowed write
  wire mode_wr  = wr_i && sel_mode && (bit_mask_i == 8'hff) && !mode_written; // R1
  wire sys_wr   = wr_i && sel_sys;
  wire [7:0] sys_clock_select_reg = {cpu_clock_status, cpu_clock_choice,
                                     main_source_status, main_source_choice, 4'h0};
  wire [7:0] sys_merged = (sys_clock_select_reg & ~bit_mask_i) | (wdata_i & bit_mask_i);
  wire [7:0] next_rdata = !rd_i ? 8'h00 :
                          sel_mode ? pin_osc_mode_reg :      // R2
                          sel_sys ? sys_clock_select_reg : 8'h00;
  wire [1:0] main_pins = {pin_osc_mode_reg[main_ext_bit], pin_osc_mode_reg[main_osc_bit]};
  wire [1:0] sub_pins  = {pin_osc_mode_reg[sub_ext_bit], pin_osc_mode_reg[sub_osc_bit]};
  // R4 R5
  wire [1:0] next_main_mode = (main_pins == 2'h1) ? pin_crystal :
                              (main_pins == 2'h3) ? pin_ext_clock : pin_input_port;
  wire [1:0] next_sub_mode  = (sub_pins == 2'h1) ? pin_crystal :
                              (sub_pins == 2'h3) ? pin_ext_clock : pin_input_port;
  wire main_pin_used = next_main_mode != pin_input_port;
  wire next_main_en  = main_pin_used && !main_osc_halt_i; // R18

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_osc_mode_reg <= pin_osc_mode_rst; // R3
      mode_written     <= 1'b0;
    end
    else if (mode_wr)
    begin
      pin_osc_mode_reg <= wdata_i; // R1
      mode_written     <= 1'b1;
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      main_source_choice <= sys_clock_sel_rst[main_choice_bit]; // R10
      cpu_clock_choice   <= sys_clock_sel_rst[cpu_choice_bit];
    end
    else if (sys_wr)
    begin
      main_source_choice <= sys_merged[main_choice_bit]; // R14
      cpu_clock_choice   <= sys_merged[cpu_choice_bit]; // R12
    end
  end

  // main source switch: onchip fast clock versus high-speed system clock
  clock_switch main_switch (
    .ref_clk_i    (ref_clk_i),
    .rstn_i       (rstn_i),
    .request_i    (main_source_choice),
    .src1_ready_i (main_ready_i && next_main_en),
    .gate0_o      (onchip_gate),
    .gate1_o      (main_ext_gate),
    .status_o     (main_source_status) // R13
  );

  // cpu switch: main system clock versus subsystem clock, shared by peripherals
  clock_switch cpu_switch (
    .ref_clk_i    (ref_clk_i),
    .rstn_i       (rstn_i),
    .request_i    (cpu_clock_choice),
    .src1_ready_i (sub_ready_i && next_sub_mode != pin_input_port),
    .gate0_o      (main_gate),
    .gate1_o      (sub_gate),
    .status_o     (cpu_clock_status) // R11
  );

  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      rdata_o           <= 8'h00;
      main_pin_mode_o   <= pin_input_port;
      sub_pin_mode_o    <= pin_input_port;
      sub_drive_o       <= 2'h0;
      main_freq_range_o <= 1'b0;
      main_osc_enable_o <= 1'b0;
      onchip_gate_o     <= 1'b1;
      main_ext_gate_o   <= 1'b0;
      main_clk_gate_o   <= 1'b1;
      sub_clk_gate_o    <= 1'b0;
    end
    else
    begin
      rdata_o           <= next_rdata;
      main_pin_mode_o   <= next_main_mode; // R4
      sub_pin_mode_o    <= next_sub_mode; // R5
      sub_drive_o       <= {pin_osc_mode_reg[sub_drive_hi_bit],
                            pin_osc_mode_reg[sub_drive_lo_bit]}; // R6
      main_freq_range_o <= pin_osc_mode_reg[main_freq_bit]; // R7
      main_osc_enable_o <= next_main_en; // R18
      onchip_gate_o     <= onchip_gate;
      main_ext_gate_o   <= main_ext_gate;
      main_clk_gate_o   <= main_gate; // R17
      sub_clk_gate_o    <= sub_gate; // R17
    end
  end
endmodule

// ### clock_source_mode_select_monitor.sv
/* port checker for the clock mode and select block.
   assumes one clock domain with an async active-low reset. */
`timescale 1ns/1ps
module clock_source_mode_select_monitor
  import clock_mode_pkg::*;
(
  input wire logic        ref_clk_i,
  input wire logic        rstn_i,
  input wire logic [19:0] addr_i,
  input wire logic        wr_i,
  input wire logic        rd_i,
  input wire logic [7:0]  bit_mask_i,
  input wire logic [7:0]  wdata_i,
  input wire logic        main_osc_halt_i,
  input wire logic        main_ready_i,
  input wire logic        sub_ready_i,
  input wire logic [7:0]  rdata_o,
  input wire logic [1:0]  main_pin_mode_o,
  input wire logic [1:0]  sub_pin_mode_o,
  input wire logic [1:0]  sub_drive_o,
  input wire logic        main_osc_enable_o,
  input wire logic        onchip_gate_o,
  input wire logic        main_ext_gate_o,
  input wire logic        main_clk_gate_o,
  input wire logic        sub_clk_gate_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);
  // decoded outputs lag the accepted write, so the stable check starts late
  logic [3:0] once_sr;
  logic       mode_wr;
  assign mode_wr = wr_i && bit_mask_i == 8'hff && addr_i == pin_osc_mode_addr;
  always_ff @(posedge ref_clk_i or negedge rstn_i)
    if (!rstn_i) once_sr <= 4'h0;
    else once_sr <= {once_sr[2:0], once_sr[0] | mode_wr};
  a_rdata_idle: assert property (!rd_i |=> rdata_o == 8'h00)
    else $error("read data not zero outside a read");
  a_mode_once: assert property (once_sr[3]
    |-> $stable({main_pin_mode_o, sub_pin_mode_o, sub_drive_o})) else $error("mode changed");
  a_osc_off: assert property ((main_osc_halt_i || main_pin_mode_o == 2'h0) [*3]
    |-> !main_osc_enable_o) else $error("main oscillator enabled while halted");
  a_main_excl: assert property (!(onchip_gate_o && main_ext_gate_o))
    else $error("both main source gates open");
  a_cpu_excl: assert property (!(main_clk_gate_o && sub_clk_gate_o))
    else $error("both cpu clock gates open");
  a_ext_ready: assert property ($rose(main_ext_gate_o)
    |-> $past(main_ready_i) && main_pin_mode_o != 2'h0) else $error("ext gate opened early");
  a_sub_ready: assert property ($rose(sub_clk_gate_o)
    |-> $past(sub_ready_i) && sub_pin_mode_o != 2'h0) else $error("sub gate opened early");
  a_sel_low: assert property (rd_i && addr_i == sys_clock_sel_addr
    |=> rdata_o[3:0] == 4'h0) else $error("select low bits not zero");
  a_switch_time: assert property (wr_i && addr_i == sys_clock_sel_addr && bit_mask_i[4]
    && wdata_i[4] && main_ready_i && main_pin_mode_o != 2'h0 && !main_osc_halt_i
    |-> ##[1:16] main_ext_gate_o) else $error("main source switch too slow");
endmodule
bind clock_source_mode_select clock_source_mode_select_monitor u_clock_source_mode_select_monitor (.*);

// ### clock_source_mode_select_tb.sv
/* self-checking bench for the clock mode and select block.
   assumes the checker is bound separately; one 250 MHz clock. */
`timescale 1ns/1ps
module clock_source_mode_select_tb
  import clock_mode_pkg::*;
;
  logic        ref_clk_i, rstn_i, wr_i, rd_i, main_osc_halt_i, main_ready_i, sub_ready_i;
  logic [19:0] addr_i;
  logic [7:0]  bit_mask_i, wdata_i, rdata_o, v;
  logic [1:0]  main_pin_mode_o, sub_pin_mode_o, sub_drive_o, d;
  logic        main_freq_range_o, main_osc_enable_o, onchip_gate_o, main_ext_gate_o;
  logic        main_clk_gate_o, sub_clk_gate_o;
  logic [31:0] seed = 32'h1a;
  int          err_total, tests_run;
  wire [3:0]   gates = {onchip_gate_o, main_ext_gate_o, main_clk_gate_o, sub_clk_gate_o};
  clock_source_mode_select u_clock_source_mode_select (.*);
  initial
  begin
    ref_clk_i = 0;
    forever #2 ref_clk_i = ~ref_clk_i;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [1:0] pin_mode(input logic [1:0] p);
    return (p == 2'h1) ? pin_crystal : (p == 2'h3) ? pin_ext_clock : pin_input_port;
  endfunction
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [19:0] a, input logic [7:0] m, input logic [7:0] dat);
    @(posedge ref_clk_i) #1;
    {wr_i, addr_i, bit_mask_i, wdata_i} = {1'b1, a, m, dat};
    @(posedge ref_clk_i) #1;
    wr_i = 0;
  endtask
  task automatic rd(input logic [19:0] a, input logic [7:0] exp);
    @(posedge ref_clk_i) #1;
    {rd_i, addr_i} = {1'b1, a};
    @(posedge ref_clk_i) #1;
    rd_i = 0;
    chk(rdata_o, exp);
  endtask
  task automatic wait_gates(input logic [3:0] g);
    for (int n = 0; n < 40 && gates !== g; n++)
      @(posedge ref_clk_i) #1;
    chk({4'h0, gates}, {4'h0, g});
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial
  begin
    {wr_i, rd_i, addr_i, bit_mask_i, wdata_i} = '0;
    {main_osc_halt_i, main_ready_i, sub_ready_i} = 3'h0;
    for (int i = 0; i < 4; i++)
    begin
      rstn_i = 0;
      repeat (10) @(posedge ref_clk_i);
      #1 rstn_i = 1;
      chk({4'h0, gates}, 8'h0a);
      rd(pin_osc_mode_addr, 8'h00);
      rd(sys_clock_sel_addr, 8'h00);
      v = 8'(xs());
      d = (v[2:1] == 2'h3) ? 2'h2 : v[2:1];
      v = {i[1:0], i[1:0], 1'b0, d, v[0]};
      // a bit write must not use up the single mode write
      wr(pin_osc_mode_addr, 8'h01, ~v);
      wr(pin_osc_mode_addr, 8'hff, v);
      wr(pin_osc_mode_addr, 8'hff, ~v);
      repeat (2) @(posedge ref_clk_i);
      rd(pin_osc_mode_addr, v);
      chk({6'h0, main_pin_mode_o}, {6'h0, pin_mode(v[7:6])});
      chk({6'h0, sub_pin_mode_o}, {6'h0, pin_mode(v[5:4])});
      chk({5'h0, sub_drive_o, main_freq_range_o}, {5'h0, d, v[0]});
      v = 8'(xs());
      main_osc_halt_i = v[0];
      repeat (4) @(posedge ref_clk_i);
      #1;
      chk({7'h0, main_osc_enable_o}, {7'h0, (i % 2 == 1) && !v[0]});
      main_osc_halt_i = 0;
    end
    {main_ready_i, sub_ready_i} = 2'h3;
    repeat (4) @(posedge ref_clk_i);
    wr(sys_clock_sel_addr, 8'hff, 8'ha0);
    rd(sys_clock_sel_addr, 8'h00);
    rd(20'hfffa2, 8'h00);
    wr(sys_clock_sel_addr, 8'hff, 8'h10);
    wait_gates(4'h6);
    rd(sys_clock_sel_addr, 8'h30);
    wr(sys_clock_sel_addr, 8'h40, 8'h40);
    wait_gates(4'h5);
    rd(sys_clock_sel_addr, 8'hf0);
    wr(sys_clock_sel_addr, 8'h40, 8'h00);
    wait_gates(4'h6);
    rd(sys_clock_sel_addr, 8'h30);
    close_out();
  end
  initial
  begin
    #20000;
    err_total++;
    close_out();
  end
endmodule

// ### clock_switch.sv
/*
  glitch-free two-way clock source switch handshake.
  assumes only source 1 reports a synchronous enable-acknowledge level; source 0 is taken as always ready.
*/
`timescale 1ns/1ps
module clock_switch
  import clock_mode_pkg::*;
(
  input  wire logic ref_clk_i,
  input  wire logic rstn_i,
  input  wire logic request_i,
  input  wire logic src1_ready_i,
  output logic      gate0_o,
  output logic      gate1_o,
  output logic      status_o
);
  switch_state_type state;
  switch_state_type next_state;
  logic [sync_stages-1:0] settle;
  wire want_change = (request_i != status_o) && (!request_i || src1_ready_i);
  always_comb
  begin
    case (state)
      sw_idle: next_state = want_change ? sw_off : sw_idle;
      sw_off:  next_state = sw_wait;
      sw_wait: next_state = settle[sync_stages-1] ? sw_on : sw_wait;
      sw_on:   next_state = sw_idle;
      default: next_state = sw_idle;
    endcase
  end
  // old gate closes, then dead time, then new gate opens; status moves last
  always_ff @(posedge ref_clk_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      state    <= sw_idle;
      gate0_o  <= 1'b1;
      gate1_o  <= 1'b0;
      status_o <= 1'b0;
      settle   <= '0;
    end
    else
    begin
      state  <= next_state;
      settle <= (state == sw_wait) ? {settle[sync_stages-2:0], 1'b1} : '0;
      if (state == sw_idle && want_change)
      begin
        gate0_o <= 1'b0;
        gate1_o <= 1'b0; // R19
      end
      if (state == sw_wait && settle[sync_stages-1])
      begin
        gate0_o <= !request_i;
        gate1_o <= request_i;
      end
      if (state == sw_on)
        status_o <= gate1_o; // R19
    end
  end
endmodule
